// >>> src/spcg_pkg.sv
// shared constants and types for sleep port clock gating
package spcg_pkg;
    localparam int NUM_PORTS = 8;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] SLEEP_EN_OFFSET = 12'h118;
    localparam logic [ADDR_W-1:0] RUN_EN_OFFSET = 12'h108;
    localparam logic [ADDR_W-1:0] DEEP_EN_OFFSET = 12'h128;
    localparam logic [ADDR_W-1:0] CLK_CFG_OFFSET = 12'h060;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 12'h1f0;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET = 12'h1f4;
    localparam logic [ADDR_W-1:0] POWER_STATE_OFFSET = 12'h1f8;
    localparam int ACG_BIT = 27;
    localparam logic [31:0] EN_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [7:0] PORT_FIELD_MASK = 8'hff;
    localparam int IRQ_FAULT_BIT = 0;
    localparam int IRQ_UNMAPPED_BIT = 1;
    localparam int IRQ_W = 2;

    typedef enum logic [1:0] {
        SPCG_RUN = 2'h0,
        SPCG_SLEEP = 2'h1,
        SPCG_DEEP = 2'h3
    } spcg_power_t;

    typedef struct packed {
        logic [NUM_PORTS-1:0] run_en;
        logic [NUM_PORTS-1:0] sleep_en;
        logic [NUM_PORTS-1:0] deep_en;
        logic auto_clock_gating_select;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic bus_fault;
        spcg_power_t power;
    } spcg_state_t;
endpackage

// >>> src/spcg_port_select.sv
// per-port clock enable selection across power states
`timescale 1ns/100ps
module spcg_port_select #(
    parameter int NUM_PORTS = 8
) (
    input wire logic [NUM_PORTS-1:0] run_en,
    input wire logic [NUM_PORTS-1:0] sleep_en,
    input wire logic [NUM_PORTS-1:0] deep_en,
    input wire logic auto_clock_gating_select,
    input wire spcg_pkg::spcg_power_t power,
    output logic [NUM_PORTS-1:0] port_clk_en
);
    genvar i;
    generate
        for (i = 0; i < NUM_PORTS; i++) begin : g_port
            always_comb begin
                // sleep tables only matter with auto gating on; else run table holds
                case (power)
                    spcg_pkg::SPCG_SLEEP: port_clk_en[i] = auto_clock_gating_select ? sleep_en[i] : run_en[i];
                    spcg_pkg::SPCG_DEEP: port_clk_en[i] = auto_clock_gating_select ? deep_en[i] : run_en[i];
                    default: port_clk_en[i] = run_en[i];
                endcase
            end
        end
    endgenerate
endmodule // spcg_port_select

// >>> src/spcg_top.sv
// sleep-mode port clock gating control with register port
// Contract
// - a set enable bit gives its port a clock
// - a clear enable bit withholds the clock from its port
// - access to an unclocked port raises a bus fault
// - reset clears all enables, register reads zero
// - port A at bit 0 through port H at bit 7, read/write
// - bits 31 to 8 read zero and ignore writes
// - run table in run, sleep table in sleep, deep table in deep sleep
// - sleep settings apply only with auto clock gating select set
// - sleep enable register sits at offset 0x118
`timescale 1ns/100ps
module spcg_top #(
    parameter int NUM_PORTS = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [spcg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    input wire logic port_access,
    input wire logic [2:0] port_access_sel,
    output logic [NUM_PORTS-1:0] port_clk_en,
    output logic bus_fault,
    output logic irq
);
    localparam int IRQ_W_L = spcg_pkg::IRQ_W;
    localparam int PWR_W = $bits(spcg_pkg::spcg_power_t);
    // access select is three bits wide, room for eight ports
    localparam int SEL_W = 3;

    spcg_pkg::spcg_state_t st_reg;
    spcg_pkg::spcg_state_t st_next;
    spcg_pkg::spcg_power_t power_next;

    logic sleep_meta_reg;
    logic sleep_sync_reg;
    logic deep_meta_reg;
    logic deep_sync_reg;

    logic [NUM_PORTS-1:0] sel_en;
    logic [NUM_PORTS-1:0] sel_onehot;
    logic [NUM_PORTS-1:0] port_fault;
    logic [NUM_PORTS-1:0] wr_field;

    logic [IRQ_W_L-1:0] irq_event;
    logic [IRQ_W_L-1:0] irq_status_next;
    logic [IRQ_W_L-1:0] irq_pending;

    logic hit_sleep;
    logic hit_run;
    logic hit_deep;
    logic hit_cfg;
    logic hit_stat;
    logic hit_mask;
    logic hit_pwr;

    logic mapped;

    logic wr_sleep;
    logic wr_run;
    logic wr_deep;
    logic wr_cfg;
    logic wr_mask;

    logic rd_sleep;
    logic rd_run;
    logic rd_deep;
    logic rd_cfg;
    logic rd_stat;
    logic rd_mask;
    logic rd_pwr;

    logic [31:0] rd_mux;

    // power state requests come from outside this clock domain
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sleep_meta_reg <= 1'b0;
        end else begin
            sleep_meta_reg <= sleep_req;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            sleep_sync_reg <= 1'b0;
        end else begin
            sleep_sync_reg <= sleep_meta_reg;
        end
    end

    // only the second flop reads the first; logic sees the second
    always_ff @(posedge clock) begin
        if (!nrst) begin
            deep_meta_reg <= 1'b0;
        end else begin
            deep_meta_reg <= deep_sleep_req;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            deep_sync_reg <= 1'b0;
        end else begin
            deep_sync_reg <= deep_meta_reg;
        end
    end

    // deep sleep takes priority when both requests stand
    always_comb begin
        case ({deep_sync_reg, sleep_sync_reg})
            2'b00: begin
                power_next = spcg_pkg::SPCG_RUN;
            end
            2'b01: begin
                power_next = spcg_pkg::SPCG_SLEEP;
            end
            2'b10: begin
                power_next = spcg_pkg::SPCG_DEEP;
            end
            2'b11: begin
                power_next = spcg_pkg::SPCG_DEEP;
            end
            default: begin
                power_next = spcg_pkg::SPCG_RUN;
            end
        endcase
    end

    // one-hot decode of the register offset
    always_comb begin
        hit_sleep = 1'b0;
        hit_run = 1'b0;
        hit_deep = 1'b0;
        hit_cfg = 1'b0;
        hit_stat = 1'b0;
        hit_mask = 1'b0;
        hit_pwr = 1'b0;

        case (reg_addr)
            spcg_pkg::SLEEP_EN_OFFSET: begin
                hit_sleep = 1'b1;
            end

            spcg_pkg::RUN_EN_OFFSET: begin
                hit_run = 1'b1;
            end

            spcg_pkg::DEEP_EN_OFFSET: begin
                hit_deep = 1'b1;
            end

            spcg_pkg::CLK_CFG_OFFSET: begin
                hit_cfg = 1'b1;
            end

            spcg_pkg::IRQ_STATUS_OFFSET: begin
                hit_stat = 1'b1;
            end

            spcg_pkg::IRQ_MASK_OFFSET: begin
                hit_mask = 1'b1;
            end

            spcg_pkg::POWER_STATE_OFFSET: begin
                hit_pwr = 1'b1;
            end

            default: begin
                hit_sleep = 1'b0;
            end
        endcase
    end

    // unknown offsets read zero and flag an interrupt
    assign mapped = hit_sleep | hit_run | hit_deep | hit_cfg | hit_stat | hit_mask | hit_pwr;

    // write strobes qualified by the decoded offset
    assign wr_sleep = reg_write & hit_sleep;
    assign wr_run = reg_write & hit_run;
    assign wr_deep = reg_write & hit_deep;
    assign wr_cfg = reg_write & hit_cfg;
    assign wr_mask = reg_write & hit_mask;

    // read strobes; power state and status have no write path
    assign rd_sleep = reg_read & hit_sleep;
    assign rd_run = reg_read & hit_run;
    assign rd_deep = reg_read & hit_deep;
    assign rd_cfg = reg_read & hit_cfg;
    assign rd_stat = reg_read & hit_stat;
    assign rd_mask = reg_read & hit_mask;
    assign rd_pwr = reg_read & hit_pwr;

    // reserved bits of every register read as zero
    always_comb begin
        rd_mux = '0;

        if (rd_sleep) begin
            rd_mux[NUM_PORTS-1:0] = st_reg.sleep_en;
        end

        if (rd_run) begin
            rd_mux[NUM_PORTS-1:0] = st_reg.run_en;
        end

        if (rd_deep) begin
            rd_mux[NUM_PORTS-1:0] = st_reg.deep_en;
        end

        if (rd_cfg) begin
            rd_mux[spcg_pkg::ACG_BIT] = st_reg.auto_clock_gating_select;
        end

        if (rd_stat) begin
            rd_mux[IRQ_W_L-1:0] = st_reg.irq_status;
        end

        if (rd_mask) begin
            rd_mux[IRQ_W_L-1:0] = st_reg.irq_mask;
        end

        if (rd_pwr) begin
            rd_mux[PWR_W-1:0] = st_reg.power;
        end
    end

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            assign sel_onehot[p] = (port_access_sel == SEL_W'(p));
            // a gated port answers any access with a fault
            assign port_fault[p] = port_access & sel_onehot[p] & ~sel_en[p];
            // only the low port field is stored; upper bits dropped
            assign wr_field[p] = reg_wdata[p];
            assign port_clk_en[p] = sel_en[p];
        end
    endgenerate

    // status events: a gated access and an unmapped offset
    assign irq_event[spcg_pkg::IRQ_FAULT_BIT] = |port_fault;
    assign irq_event[spcg_pkg::IRQ_UNMAPPED_BIT] = (reg_read | reg_write) & ~mapped;

    genvar b;
    generate
        for (b = 0; b < IRQ_W_L; b++) begin : g_irq
            // set wins over a read-clear in the same cycle
            assign irq_status_next[b] = irq_event[b] | (st_reg.irq_status[b] & ~rd_stat);
        end
    endgenerate

    // one mux per port picks the table for the current power state
    spcg_port_select #(
        .NUM_PORTS(NUM_PORTS)
    ) u_select (
        .run_en(st_reg.run_en),
        .sleep_en(st_reg.sleep_en),
        .deep_en(st_reg.deep_en),
        .auto_clock_gating_select(st_reg.auto_clock_gating_select),
        .power(st_reg.power),
        .port_clk_en(sel_en)
    );

    always_comb begin
        st_next = st_reg;
        st_next.power = power_next;
        // data stands one cycle, then the port falls back to zero
        st_next.rdata = rd_mux;
        st_next.bus_fault = |port_fault;
        st_next.irq_status = irq_status_next;

        // writes land one cycle after the strobe
        if (wr_sleep) begin
            st_next.sleep_en = wr_field;
        end else begin
            st_next.sleep_en = st_reg.sleep_en;
        end

        if (wr_run) begin
            st_next.run_en = wr_field;
        end else begin
            st_next.run_en = st_reg.run_en;
        end

        if (wr_deep) begin
            st_next.deep_en = wr_field;
        end else begin
            st_next.deep_en = st_reg.deep_en;
        end

        if (wr_cfg) begin
            st_next.auto_clock_gating_select = reg_wdata[spcg_pkg::ACG_BIT];
        end else begin
            st_next.auto_clock_gating_select = st_reg.auto_clock_gating_select;
        end

        if (wr_mask) begin
            st_next.irq_mask = reg_wdata[IRQ_W_L-1:0];
        end else begin
            st_next.irq_mask = st_reg.irq_mask;
        end
    end

    // synchronous reset; every port starts unclocked
    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_reg.run_en <= spcg_pkg::EN_RESET[NUM_PORTS-1:0];
            st_reg.sleep_en <= spcg_pkg::EN_RESET[NUM_PORTS-1:0];
            st_reg.deep_en <= spcg_pkg::EN_RESET[NUM_PORTS-1:0];
            st_reg.auto_clock_gating_select <= spcg_pkg::CFG_RESET[spcg_pkg::ACG_BIT];

            st_reg.irq_status <= '0;
            st_reg.irq_mask <= '0;

            st_reg.rdata <= '0;
            st_reg.bus_fault <= 1'b0;
            st_reg.power <= spcg_pkg::SPCG_RUN;
        end else begin
            st_reg <= st_next;
        end
    end

    // level interrupt while an unmasked status bit stands
    assign irq_pending = st_reg.irq_status & st_reg.irq_mask;
    assign reg_rdata = st_reg.rdata;
    assign bus_fault = st_reg.bus_fault;
    assign irq = |irq_pending;
endmodule // spcg_top

// >>> verification/sleep_port_clock_gating_test.sv
// self-checking bench for sleep port clock gating
`timescale 1ns/100ps
module sleep_port_clock_gating_test;
    localparam logic [11:0] SL = spcg_pkg::SLEEP_EN_OFFSET;
    localparam logic [11:0] RN = spcg_pkg::RUN_EN_OFFSET;
    localparam logic [11:0] DP = spcg_pkg::DEEP_EN_OFFSET;
    localparam logic [11:0] CF = spcg_pkg::CLK_CFG_OFFSET;
    localparam logic [11:0] ST = spcg_pkg::IRQ_STATUS_OFFSET;
    localparam logic [31:0] ACG_ON = 32'h1 << spcg_pkg::ACG_BIT;
    logic clock = 1'b0, nrst = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic sleep_req = 1'b0, deep_sleep_req = 1'b0, port_access = 1'b0;
    logic [2:0] port_access_sel = 3'h0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [7:0] port_clk_en;
    logic bus_fault, irq;
    int error_cnt = 0;
    int compares = 0;
    spcg_top dut_u (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req), .port_access(port_access),
        .port_access_sel(port_access_sel), .port_clk_en(port_clk_en), .bus_fault(bus_fault),
        .irq(irq));
    initial forever #50 clock = ~clock;
    task chk(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(logic [11:0] a, logic [31:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task rd(logic [11:0] a, logic [31:0] exp);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task acc(logic [2:0] s, logic f);
        @(posedge clock);
        port_access <= 1'b1;
        port_access_sel <= s;
        @(posedge clock);
        port_access <= 1'b0;
        #1 chk(32'(bus_fault), 32'(f));
    endtask
    task end_of_test;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        rd(SL, 32'h0);
        acc(3'h0, 1'b1);
        wr(spcg_pkg::IRQ_MASK_OFFSET, 32'h3);
        #1 chk(32'(irq), 32'h1);
        rd(ST, 32'h1);
        #1 chk(32'(irq), 32'h0);
        wr(RN, 32'h5);
        #1 chk(32'(port_clk_en), 32'h5);
        acc(3'h0, 1'b0);
        acc(3'h1, 1'b1);
        wr(SL, 32'hffff_ffa0);
        rd(SL, 32'ha0);
        wr(SL, 32'ha0 | 32'h01);
        rd(SL, 32'ha1);
        wr(SL, 32'ha1 & ~32'h01);
        rd(SL, 32'ha0);
        wr(CF, ACG_ON);
        sleep_req <= 1'b1;
        repeat (4) @(posedge clock);
        #1 chk(32'(port_clk_en), 32'ha0);
        rd(SL, 32'ha0);
        acc(3'h5, 1'b0);
        acc(3'h0, 1'b1);
        wr(CF, 32'h0);
        #1 chk(32'(port_clk_en), 32'h5);
        wr(DP, 32'h3c);
        wr(CF, ACG_ON);
        deep_sleep_req <= 1'b1;
        repeat (4) @(posedge clock);
        #1 chk(32'(port_clk_en), 32'h3c);
        @(posedge clock);
        sleep_req <= 1'b0;
        deep_sleep_req <= 1'b0;
        repeat (4) @(posedge clock);
        #1 chk(32'(port_clk_en), 32'h5);
        rd(12'h7fc, 32'h0);
        rd(ST, 32'h3);
        end_of_test();
    end
    initial begin
        repeat (400) @(posedge clock);
        error_cnt++;
        end_of_test();
    end
endmodule // sleep_port_clock_gating_test
bind spcg_top spcg_checker #(.NUM_PORTS(NUM_PORTS)) chk_u (.clock(clock), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
    .port_access(port_access), .port_access_sel(port_access_sel),
    .port_clk_en(port_clk_en), .bus_fault(bus_fault));

// >>> verification/spcg_checker.sv
// port-level assertions for sleep port clock gating
`timescale 1ns/100ps
module spcg_checker #(
    parameter int NUM_PORTS = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [spcg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    input wire logic port_access,
    input wire logic [2:0] port_access_sel,
    input wire logic [NUM_PORTS-1:0] port_clk_en,
    input wire logic bus_fault
);
    localparam logic [spcg_pkg::ADDR_W-1:0] SL = spcg_pkg::SLEEP_EN_OFFSET;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_fault; port_access && !port_clk_en[port_access_sel] |=> bus_fault; endproperty
    a_fault: assert property (p_fault) else $error("gated port gave no fault");
    property p_nofault; port_access && port_clk_en[port_access_sel] |=> !bus_fault; endproperty
    a_nofault: assert property (p_nofault) else $error("clocked port faulted");
    property p_cause; bus_fault |-> $past(port_access); endproperty
    a_cause: assert property (p_cause) else $error("fault without access");
    property p_rst; $rose(nrst) |-> port_clk_en == '0 && reg_rdata == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
    property p_resv; reg_read && reg_addr == SL |=> reg_rdata[31:8] == 24'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero");
    property p_back;
        reg_write && reg_addr == SL ##1 reg_read && reg_addr == SL
            |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 2);
    endproperty
    a_back: assert property (p_back) else $error("enable readback wrong");
    property p_idle; !reg_read |=> reg_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside slot");
    property p_hold;
        (!reg_write && $stable(sleep_req) && $stable(deep_sleep_req))[*5] |=> $stable(port_clk_en);
    endproperty
    a_hold: assert property (p_hold) else $error("enables moved with no cause");
endmodule // spcg_checker
